// file: pkg/smbwd_defines.svh
// constants of the smbus block write decoder
// assumes inclusion by bare name from the package and the design files
`ifndef SMBWD_DEFINES_SVH
`define SMBWD_DEFINES_SVH

// slave address: upper four bits fixed, lower three from straps
`define SMBWD_ADDR_HI       4'hd
`define SMBWD_STRAP_W       3
// frame constants
`define SMBWD_CMD_CODE      8'hbe
`define SMBWD_BYTE_COUNT    8'h08
`define SMBWD_OP_WRITE      3'h3
`define SMBWD_OP_READ       3'h4
// byte positions inside the frame, address byte first
`define SMBWD_IDX_ADDR      4'h0
`define SMBWD_IDX_CMD       4'h1
`define SMBWD_IDX_CNT       4'h2
`define SMBWD_IDX_OP        4'h3
`define SMBWD_IDX_C2        4'h4
`define SMBWD_IDX_C3        4'h5
`define SMBWD_IDX_C4        4'h6
`define SMBWD_IDX_D1        4'h7
`define SMBWD_IDX_D4        4'ha
`define SMBWD_IDX_PEC       4'hb
`define SMBWD_IDX_MAX       4'hc
// field positions
`define SMBWD_OP_MSB        2
`define SMBWD_PORT_HI_MSB   3
`define SMBWD_PORT_LO_BIT   7
`define SMBWD_BE_MSB        5
`define SMBWD_BE_LSB        2
`define SMBWD_AHI_MSB       1
// bits per byte and the ack slot
`define SMBWD_BIT_ACK       4'h8
// crc-8, polynomial x^8+x^2+x+1
`define SMBWD_CRC_POLY      8'h07
`define SMBWD_CRC_INIT      8'h00
// number of ports reachable
`define SMBWD_PORT_COUNT    6
`endif

// file: pkg/smbwd_pkg.sv
// types of the smbus block write decoder
// assumes smbwd_defines.svh on the include path
package smbwd_pkg;
  `include "smbwd_defines.svh"

  typedef enum logic [1:0] {
    SMBWD_IDLE,
    SMBWD_ACTIVE,
    SMBWD_IGNORE
  } smbwd_fsm_t;

  // write request handed to the register file
  typedef struct packed {
    logic        stb;
    logic [5:0]  port_sel;
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  be;
  } smbwd_wr_t;

  // whole state of the decoder
  typedef struct packed {
    smbwd_fsm_t  fsm;
    logic        scl_p;
    logic        sda_p;
    logic [3:0]  bit_cnt;
    logic        in_ack;
    logic [7:0]  shreg;
    logic [3:0]  idx;
    logic        bad;
    logic        rd_op;
    logic [7:0]  crc;
    logic        pec_fail;
    logic [4:0]  port;
    logic [3:0]  be;
    logic [9:0]  addr;
    logic [31:0] data;
    logic        sda_o;
    logic        sda_oe;
    smbwd_wr_t   wr;
  } smbwd_st_t;
endpackage

// file: verilog/smbwd_sync.sv
// two-flop synchroniser for pins from outside the clock domain
// assumes the inputs are levels that stay put for several clocks
`timescale 1ns/1ns
module smbwd_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // pins and synchronised copy
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule

// file: verilog/smbwd_top.sv
// smbus block write decoder: receives one config write frame and hands it on
// assumes scl from the master (no clock stretching) and an external open-drain sda wire
//
// Contract
// - command code must be BEh; wrong code NACKed with all later bytes
// - byte count must be 08h; other counts NACKed with following bytes
// - byte count never includes the optional error code byte
// - byte after fourth data byte is the error code, checked when present
// - failed error code: drop the write, NACK the error code byte
// - error check skip input suppresses the error code check
// - first command byte bits 2:0: 011b write, 100b read, rest reserved
// - port index: second byte bits 3:0 high, third byte bit 7 low
// - port index selects that port; indices 0 to 5 map directly
// - third byte bits 5:2 enable register bytes 0 through 3
// - disabled bytes stay unchanged, enabled bytes take the matching data
// - dword address from third byte bits 1:0 and fourth byte
// - first data byte is register bits 31:24, last is 7:0
// - address bits 1:0 are zero, whole aligned dword accessed
// - slave address is 1101 above three strap bits
`timescale 1ns/1ns
`include "smbwd_defines.svh"
module smbwd_top
  import smbwd_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS_IN,
  input  wire logic        SYS_RST_IN,
  // smbus pins
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_OUT,
  // address straps and control
  input  wire logic [2:0]  ADDR_STRAP_IN,
  input  wire logic        ERROR_CHECK_SKIP_IN,
  // register write request
  output logic             WR_STB_OUT,
  output logic [5:0]       WR_PORT_SEL_OUT,
  output logic [11:0]      WR_ADDR_OUT,
  output logic [31:0]      WR_DATA_OUT,
  output logic [3:0]       WR_BE_OUT
);
  localparam smbwd_st_t ST_RST = '0;

  smbwd_st_t  st_q;
  smbwd_st_t  st_d;
  logic [4:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic [2:0] strap_s;

  // crc-8 over one byte, msb first
  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ `SMBWD_CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // pins cross into the system clock here
  smbwd_sync #(
    .W(5)
  ) u_sync (
    .clk_in (CLK_SYS_IN),
    .rst_in (SYS_RST_IN),
    .d_in   ({SCL_IN, SDA_IN, ADDR_STRAP_IN}),
    .q_out  (pins_s)
  );

  assign scl_s   = pins_s[4];
  assign sda_s   = pins_s[3];
  assign strap_s = pins_s[2:0];

  // next-state logic of the whole decoder
  always_comb begin
    logic start_c;
    logic stop_c;
    logic rise_c;
    logic fall_c;
    logic nack_c;
    logic err_c;
    logic commit_c;
    start_c  = 1'b0;
    stop_c   = 1'b0;
    rise_c   = 1'b0;
    fall_c   = 1'b0;
    nack_c   = 1'b0;
    err_c    = 1'b0;
    commit_c = 1'b0;
    st_d        = st_q;
    st_d.wr.stb = 1'b0;
    st_d.scl_p  = scl_s;
    st_d.sda_p  = sda_s;
    // sda moves while scl high only for start and stop
    start_c = st_q.scl_p & scl_s & st_q.sda_p & ~sda_s;
    stop_c  = st_q.scl_p & scl_s & ~st_q.sda_p & sda_s;
    rise_c  = ~st_q.scl_p & scl_s;
    fall_c  = st_q.scl_p & ~scl_s;
    commit_c = (st_q.fsm == SMBWD_ACTIVE) && !st_q.bad && !st_q.pec_fail && !st_q.rd_op
               && (st_q.idx >= `SMBWD_IDX_PEC) && (st_q.port < 5'(`SMBWD_PORT_COUNT));

    if (start_c) begin
      // a repeated start abandons whatever frame was open
      st_d.fsm      = SMBWD_ACTIVE;
      st_d.bit_cnt  = 4'h0;
      st_d.in_ack   = 1'b0;
      st_d.idx      = `SMBWD_IDX_ADDR;
      st_d.bad      = 1'b0;
      st_d.rd_op    = 1'b0;
      st_d.crc      = `SMBWD_CRC_INIT;
      st_d.pec_fail = 1'b0;
      st_d.sda_oe   = 1'b0;
    end else if (stop_c) begin
      if (commit_c) begin
        st_d.wr.stb = 1'b1;
        for (int p = 0; p < `SMBWD_PORT_COUNT; p++) begin
          st_d.wr.port_sel[p] = (st_q.port == 5'(p));
        end
        st_d.wr.addr = {st_q.addr, 2'b00};
        st_d.wr.data = st_q.data;
        // byte enables passed with the data
        st_d.wr.be   = st_q.be;
      end
      st_d.fsm    = SMBWD_IDLE;
      st_d.sda_oe = 1'b0;
    end else if (st_q.fsm != SMBWD_IDLE) begin
      if (rise_c && !st_q.in_ack && (st_q.bit_cnt < `SMBWD_BIT_ACK)) begin
        st_d.shreg   = {st_q.shreg[6:0], sda_s};
        st_d.bit_cnt = st_q.bit_cnt + 4'h1;
      end
      if (fall_c && st_q.in_ack) begin
        // ack slot over: release the line, next byte
        st_d.in_ack  = 1'b0;
        st_d.sda_oe  = 1'b0;
        st_d.bit_cnt = 4'h0;
        if (st_q.idx < `SMBWD_IDX_MAX) begin
          st_d.idx = st_q.idx + 4'h1;
        end
      end else if (fall_c && (st_q.bit_cnt == `SMBWD_BIT_ACK)) begin
        st_d.in_ack = 1'b1;
        case (st_q.idx)
          `SMBWD_IDX_ADDR: begin
            // strap address match, write direction only
            if (st_q.shreg[7:1] != {`SMBWD_ADDR_HI, strap_s} || st_q.shreg[0]) begin
              st_d.fsm = SMBWD_IGNORE;
            end
          end
          `SMBWD_IDX_CMD: err_c = (st_q.shreg != `SMBWD_CMD_CODE);
          // count of eight, error code byte not counted
          `SMBWD_IDX_CNT: err_c = (st_q.shreg != `SMBWD_BYTE_COUNT);
          `SMBWD_IDX_OP: begin
            if (st_q.shreg[`SMBWD_OP_MSB:0] == `SMBWD_OP_READ) begin
              st_d.rd_op = 1'b1;
            end else if (st_q.shreg[`SMBWD_OP_MSB:0] != `SMBWD_OP_WRITE) begin
              err_c = 1'b1;
            end
          end
          `SMBWD_IDX_C2: st_d.port[4:1] = st_q.shreg[`SMBWD_PORT_HI_MSB:0];
          `SMBWD_IDX_C3: begin
            st_d.port[0]   = st_q.shreg[`SMBWD_PORT_LO_BIT];
            st_d.be        = st_q.shreg[`SMBWD_BE_MSB:`SMBWD_BE_LSB];
            st_d.addr[9:8] = st_q.shreg[`SMBWD_AHI_MSB:0];
          end
          `SMBWD_IDX_C4: st_d.addr[7:0] = st_q.shreg;
          `SMBWD_IDX_PEC: begin
            if (!ERROR_CHECK_SKIP_IN && (st_q.crc != st_q.shreg)) begin
              st_d.pec_fail = 1'b1;
              nack_c        = 1'b1;
            end
          end
          default: begin
            if (st_q.idx > `SMBWD_IDX_PEC) begin
              err_c = 1'b1; // nothing may follow the error code byte
            end else begin
              // first data byte lands in bits 31:24
              st_d.data = {st_q.data[23:0], st_q.shreg};
            end
          end
        endcase
        // crc over address byte through fourth data byte
        if (st_q.idx <= `SMBWD_IDX_D4) begin
          st_d.crc = crc_step(st_q.crc, st_q.shreg);
        end
        // a bad byte poisons the rest of the frame
        if (err_c) begin
          st_d.bad = 1'b1;
        end
        // pull low to acknowledge, release to refuse
        st_d.sda_oe = !(nack_c || err_c || st_q.bad) && (st_d.fsm == SMBWD_ACTIVE);
      end
    end
  end

  // single state register
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign SDA_OUT         = st_q.sda_o; // always low, open drain
  assign SDA_OE_OUT      = st_q.sda_oe;
  assign WR_STB_OUT      = st_q.wr.stb;
  assign WR_PORT_SEL_OUT = st_q.wr.port_sel;
  assign WR_ADDR_OUT     = st_q.wr.addr;
  assign WR_DATA_OUT     = st_q.wr.data;
  assign WR_BE_OUT       = st_q.wr.be;
endmodule

// file: verification/smbwd_monitor.sv
// port checker of the block write decoder
// assumes a bind onto smbwd_top, one clock domain
`timescale 1ns/1ns
module smbwd_monitor (
  // clock and reset
  input wire logic        CLK_SYS_IN,
  input wire logic        SYS_RST_IN,
  // smbus pins
  input wire logic        SCL_IN,
  input wire logic        SDA_IN,
  input wire logic        SDA_OE_OUT,
  // write request
  input wire logic        WR_STB_OUT,
  input wire logic [5:0]  WR_PORT_SEL_OUT,
  input wire logic [11:0] WR_ADDR_OUT,
  input wire logic [31:0] WR_DATA_OUT,
  input wire logic [3:0]  WR_BE_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);
  logic [3:0] since_stop_q;
  // cycles since a raw stop; saturates so an old stop never looks fresh
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      since_stop_q <= 4'hf;
    end else if (SCL_IN && $rose(SDA_IN)) begin
      since_stop_q <= 4'h0;
    end else if (since_stop_q != 4'hf) begin
      since_stop_q <= since_stop_q + 4'h1;
    end
  end
  strobe_pulse_a: assert property (WR_STB_OUT |=> !WR_STB_OUT)
    else $error("write strobe longer than one cycle");
  strobe_after_stop_a: assert property (WR_STB_OUT |-> since_stop_q >= 4'h1 && since_stop_q <= 4'h7)
    else $error("write strobe not just after a stop");
  strobe_idle_bus_a: assert property (WR_STB_OUT |-> SCL_IN && SDA_IN)
    else $error("write strobe while bus busy");
  addr_align_a: assert property (WR_STB_OUT |-> WR_ADDR_OUT[1:0] == 2'b00)
    else $error("write address not dword aligned");
  port_onehot_a: assert property (WR_STB_OUT |-> $onehot(WR_PORT_SEL_OUT))
    else $error("port select not one-hot");
  fields_hold_a: assert property (!WR_STB_OUT |-> $stable({WR_PORT_SEL_OUT, WR_ADDR_OUT, WR_DATA_OUT, WR_BE_OUT}))
    else $error("write fields moved without strobe");
  ack_scl_low_a: assert property ($changed(SDA_OE_OUT) |-> !SCL_IN)
    else $error("ack drive changed while scl high");
  ack_width_a: assert property ($rose(SDA_OE_OUT) |-> SDA_OE_OUT [*8] ##[4:12] !SDA_OE_OUT)
    else $error("ack drive not one bit long");
  cover property (WR_STB_OUT);
  cover property ($rose(SDA_OE_OUT));
  cover property (SCL_IN && $rose(SDA_IN));
endmodule

bind smbwd_top smbwd_monitor smbwd_monitor_i (
  .CLK_SYS_IN(CLK_SYS_IN), .SYS_RST_IN(SYS_RST_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OE_OUT(SDA_OE_OUT), .WR_STB_OUT(WR_STB_OUT), .WR_PORT_SEL_OUT(WR_PORT_SEL_OUT),
  .WR_ADDR_OUT(WR_ADDR_OUT), .WR_DATA_OUT(WR_DATA_OUT), .WR_BE_OUT(WR_BE_OUT));

// file: verification/smbwd_master.sv
// smbus master model: drives scl, pulls sda low, records ack slots
// assumes a pulled-up sda wire resolved by the bench
`timescale 1ns/1ns
module smbwd_master (
  // bus lines
  output logic       scl_out,
  output logic       sda_low_out,
  input  wire logic  sda_in
);
  logic [15:0] acks; // room for a byte beyond the error code byte
  // idle bus: scl stands high, sda released
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic put_byte(input logic [7:0] b, input int k);
    for (int i = 7; i >= 0; i--) begin
      sda_low_out = ~b[i];
      #16 scl_out = 1'b1;
      #32 scl_out = 1'b0;
      #16;
    end
    sda_low_out = 1'b0;
    #16 scl_out = 1'b1;
    #16 acks[k] = sda_in;
    #16 scl_out = 1'b0;
    #16;
  endtask
  // one whole frame, start to stop, 64 ns per bit
  task automatic frame(input logic [7:0] fb[$]);
    acks = 16'h0000;
    #32 sda_low_out = 1'b1;
    #32 scl_out = 1'b0;
    #16;
    foreach (fb[k]) put_byte(fb[k], k);
    sda_low_out = 1'b1;
    #16 scl_out = 1'b1;
    #32 sda_low_out = 1'b0;
    #32;
  endtask
endmodule

// file: verification/testbench.sv
// self-checking bench of the block write decoder
// assumes smbwd_master on the bus and smbwd_monitor bound to the top
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic        clk;
  logic        rst;
  logic [2:0]  strap;
  logic        skip;
  logic        m_scl;
  logic        m_low;
  logic        oe;
  logic        sda_o;
  logic        stb;
  logic [5:0]  psel;
  logic [11:0] addr;
  logic [31:0] data;
  logic [3:0]  be;
  logic [3:0]  n_stb;
  logic [7:0]  fq[$];
  int          n_fail;
  int          compares;
  wire         sda = ~((oe & ~sda_o) | m_low);

  smbwd_top smbwd_top_i (
    .CLK_SYS_IN(clk), .SYS_RST_IN(rst), .SCL_IN(m_scl), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_OUT(oe),
    .ADDR_STRAP_IN(strap), .ERROR_CHECK_SKIP_IN(skip), .WR_STB_OUT(stb), .WR_PORT_SEL_OUT(psel),
    .WR_ADDR_OUT(addr), .WR_DATA_OUT(data), .WR_BE_OUT(be));
  smbwd_master smbwd_master_i (.scl_out(m_scl), .sda_low_out(m_low), .sda_in(sda));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // strobes counted since reset; each run looks at the difference, so one driver only
  always @(posedge clk) begin
    if (rst) begin
      n_stb <= 4'h0;
    end else if (stb === 1'b1) begin
      n_stb <= n_stb + 4'h1;
    end
  end
  // crc-8 of the bench, poly 07h from zero
  function automatic logic [7:0] crc8(input logic [7:0] q[$]);
    logic [7:0] c;
    c = 8'h00;
    foreach (q[k]) begin
      c = c ^ q[k];
      for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  task automatic drive(input logic [2:0] s, input logic k);
    @(posedge clk);
    #1;
    strap = s;
    skip = k;
  endtask
  // send fq, then judge ack slots and the write request
  task automatic run(input int nak, input logic wr, input logic [5:0] e_ps, input logic [11:0] e_ad,
                     input logic [31:0] e_dt, input logic [3:0] e_be);
    logic [15:0] e_ack;
    logic [3:0]  s0;
    e_ack = 16'h0000;
    s0 = n_stb;
    for (int k = nak; k < fq.size(); k++) e_ack[k] = 1'b1;
    smbwd_master_i.frame(fq);
    repeat (2) @(posedge clk);
    `CHK(smbwd_master_i.acks, e_ack)
    `CHK(4'(n_stb - s0), {3'h0, wr})
    `CHK(sda_o, 1'b0)
    if (wr) begin
      `CHK(psel, e_ps)
      `CHK(addr, e_ad)
      `CHK(data, e_dt)
      `CHK(be, e_be)
    end
  endtask
  task automatic t_sample;
    drive(3'h0, 1'b0);
    fq = {8'hd0, 8'hbe, 8'h08, 8'h03, 8'h00, 8'hbc, 8'h3e, 8'h12, 8'h34, 8'h56, 8'h78};
    run(11, 1'b1, 6'h02, 12'h0f8, 32'h12345678, 4'hf);
  endtask
  task automatic t_pec;
    drive(3'h1, 1'b0);
    fq = {8'hd2, 8'hbe, 8'h08, 8'h03, 8'h02, 8'h95, 8'h40, 8'hca, 8'hfe, 8'h01, 8'h23};
    fq.push_back(crc8(fq));
    run(12, 1'b1, 6'h20, 12'h500, 32'hcafe0123, 4'h5);
    fq[11] = ~fq[11];
    run(11, 1'b0, 6'h20, 12'h500, 32'hcafe0123, 4'h5);
    drive(3'h1, 1'b1);
    fq[10] = 8'h45;
    run(12, 1'b1, 6'h20, 12'h500, 32'hcafe0145, 4'h5);
    // a byte past the error code byte is refused and spoils the write
    fq.push_back(8'h00);
    run(12, 1'b0, 6'h20, 12'h500, 32'hcafe0145, 4'h5);
  endtask
  task automatic t_refuse;
    logic [7:0] val [5] = '{8'hd0, 8'hbf, 8'h07, 8'h04, 8'h03};
    int         nak [5] = '{0, 1, 2, 11, 11};
    drive(3'h1, 1'b0);
    // spoil one byte: address, code, count, read op, port 7
    for (int j = 0; j < 5; j++) begin
      fq = {8'hd2, 8'hbe, 8'h08, 8'h03, 8'h00, 8'hbc, 8'h3e, 8'h12, 8'h34, 8'h56, 8'h78};
      fq[j] = val[j];
      run(nak[j], 1'b0, 6'h00, 12'h000, 32'h0, 4'h0);
    end
  endtask
  task automatic results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    strap = 3'h0;
    skip = 1'b0;
    n_fail = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge clk);
    t_sample;
    t_pec;
    t_refuse;
    results;
  end
  // watchdog well beyond the ten frames
  initial begin
    #200000;
    n_fail++;
    results;
  end
endmodule
